// >>> hw/tap_port.sv
/*
 Test access port: tap controller, instruction register, one user data
 register, a data FIFO toward the core and a falling-edge output stage.
 Assumes the host drives the test clock only while operating the port and
 keeps mode-select stable around each rising edge.
*/
// Overview of operation
// - Serial input bits are captured on the rising test-clock edge.
// - The serial output changes only on the falling test-clock edge.
// - The serial output is tri-stated unless a shift state is active.
// - The tap controller steps only on rising edges, steered by mode-select.

module tap_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  input wire logic wr_valid_in,
  output logic wr_ready_out,
  output logic [WIDTH-1:0] rd_data_out,
  output logic rd_valid_out,
  input wire logic rd_ready_in
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
  } fifo_state_type;
  fifo_state_type s_r, s_nxt;
  logic [WIDTH-1:0] mem [DEPTH];
  logic full, empty;

  assign full = (s_r.wp[AW] != s_r.rp[AW]) && (s_r.wp[AW-1:0] == s_r.rp[AW-1:0]);
  assign empty = s_r.wp == s_r.rp;
  assign wr_ready_out = !full;
  assign rd_valid_out = !empty;
  assign rd_data_out = mem[s_r.rp[AW-1:0]];

  always_comb begin
    s_nxt = s_r;
    if (wr_valid_in && !full) begin
      s_nxt.wp = s_r.wp + 1'b1;
    end
    if (rd_ready_in && !empty) begin
      s_nxt.rp = s_r.rp + 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (wr_valid_in && !full) begin
      mem[s_r.wp[AW-1:0]] <= wr_data_in;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule

module tap_port
  import tap_pkg::*;
(
  // Clocks and reset
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic test_clk_in,
  // Test link pins
  input wire logic test_mode_in,
  input wire logic test_data_in,
  output logic test_data_out,
  output logic test_data_oe_out,
  // Core side data stream
  output logic [DR_WIDTH-1:0] core_data_out,
  output logic core_valid_out,
  input wire logic core_ready_in,
  // Status
  output logic [IR_WIDTH-1:0] instr_out,
  output logic fifo_full_out
);

  typedef struct packed {
    tap_state_type st;
    logic [IR_WIDTH-1:0] ir_shift;
    logic [IR_WIDTH-1:0] ir;
    logic [DR_WIDTH-1:0] dr_shift;
    logic [DR_WIDTH-1:0] dr_word;
    logic tgl;
    logic ir_tgl;
    logic tdo_rise;
  } link_state_type;

  typedef struct packed {
    logic tdo;
    logic oe;
  } out_state_type;

  typedef struct packed {
    logic [2:0] tgl_sync;
    logic [2:0] ir_sync;
    logic [DR_WIDTH-1:0] word;
    logic push;
    logic [DR_WIDTH-1:0] data;
    logic valid;
    logic [IR_WIDTH-1:0] instr;
    logic full;
  } core_state_type;

  link_state_type l_r, l_nxt;
  out_state_type o_r, o_nxt;
  core_state_type c_r, c_nxt;
  logic wr_ready;
  logic [DR_WIDTH-1:0] rd_data;
  logic rd_valid;
  logic pop;
  link_in_type pins;
  link_out_type pout;

  assign pins.tms = test_mode_in;
  assign pins.tdi = test_data_in;

  always_comb begin
    l_nxt = l_r;
    unique case (l_r.st)
      st_reset: l_nxt.st = pins.tms ? st_reset : st_idle;
      st_idle: l_nxt.st = pins.tms ? st_dr_select : st_idle;
      st_dr_select: l_nxt.st = pins.tms ? st_ir_select : st_dr_capture;
      st_dr_capture: l_nxt.st = pins.tms ? st_dr_exit1 : st_dr_shift;
      st_dr_shift: l_nxt.st = pins.tms ? st_dr_exit1 : st_dr_shift;
      st_dr_exit1: l_nxt.st = pins.tms ? st_dr_update : st_dr_pause;
      st_dr_pause: l_nxt.st = pins.tms ? st_dr_exit2 : st_dr_pause;
      st_dr_exit2: l_nxt.st = pins.tms ? st_dr_update : st_dr_shift;
      st_dr_update: l_nxt.st = pins.tms ? st_dr_select : st_idle;
      st_ir_select: l_nxt.st = pins.tms ? st_reset : st_ir_capture;
      st_ir_capture: l_nxt.st = pins.tms ? st_ir_exit1 : st_ir_shift;
      st_ir_shift: l_nxt.st = pins.tms ? st_ir_exit1 : st_ir_shift;
      st_ir_exit1: l_nxt.st = pins.tms ? st_ir_update : st_ir_pause;
      st_ir_pause: l_nxt.st = pins.tms ? st_ir_exit2 : st_ir_pause;
      st_ir_exit2: l_nxt.st = pins.tms ? st_ir_update : st_ir_shift;
      st_ir_update: l_nxt.st = pins.tms ? st_dr_select : st_idle;
    endcase
    unique case (l_r.st)
      st_reset: l_nxt.ir = IR_RESET;
      st_ir_capture: l_nxt.ir_shift = IR_CAPTURE;
      st_ir_shift: l_nxt.ir_shift = {pins.tdi, l_r.ir_shift[IR_WIDTH-1:1]};
      st_ir_update: l_nxt.ir = l_r.ir_shift;
      st_dr_capture: l_nxt.dr_shift = l_r.dr_word;
      st_dr_shift: l_nxt.dr_shift = {pins.tdi, l_r.dr_shift[DR_WIDTH-1:1]};
      st_dr_update: begin
        if (l_r.ir == IR_USER_DATA) begin
          l_nxt.dr_word = l_r.dr_shift;
          l_nxt.tgl = !l_r.tgl;
        end
      end
      default: ;
    endcase
    // Entering reset restores the instruction at once, not one edge later
    if (l_nxt.st == st_reset) begin
      l_nxt.ir = IR_RESET;
    end
    // Every instruction change is flagged by a toggle for the core side
    l_nxt.ir_tgl = l_r.ir_tgl ^ (l_nxt.ir != l_r.ir);
    // Output level seen at the rising edge, for the falling-edge check only
    l_nxt.tdo_rise = o_r.tdo;
  end

  // Mode-select stable before the edge is the host's duty; sampled raw here
  always_ff @(posedge test_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      l_r <= '{st: st_reset, ir: IR_RESET, default: '0};
    end else begin
      l_r <= l_nxt;
    end
  end

  always_comb begin
    o_nxt.oe = (l_r.st == st_ir_shift) || (l_r.st == st_dr_shift);
    o_nxt.tdo = (l_r.st == st_ir_shift) ? l_r.ir_shift[0] : l_r.dr_shift[0];
  end

  // Falling edge gives the host a half period of hold at its rising sample
  always_ff @(negedge test_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      o_r <= '0;
    end else begin
      o_r <= o_nxt;
    end
  end

  assign pout.tdo = o_r.tdo;
  assign pout.tdo_oe = o_r.oe;
  assign test_data_out = pout.tdo;
  assign test_data_oe_out = pout.tdo_oe;

  // Word and instruction are stable long before the toggle is seen in core domain
  assign pop = !c_r.valid || core_ready_in;

  always_comb begin
    c_nxt = c_r;
    c_nxt.tgl_sync = {c_r.tgl_sync[1:0], l_r.tgl};
    c_nxt.ir_sync = {c_r.ir_sync[1:0], l_r.ir_tgl};
    // Instruction word is taken only once its toggle has crossed
    if (c_r.ir_sync[2] != c_r.ir_sync[1]) begin
      c_nxt.instr = l_r.ir;
    end
    c_nxt.push = 1'b0;
    if (c_r.tgl_sync[2] != c_r.tgl_sync[1]) begin
      c_nxt.word = l_r.dr_word;
      c_nxt.push = 1'b1;
    end
    if (pop) begin
      c_nxt.valid = rd_valid;
      c_nxt.data = rd_valid ? rd_data : c_r.data;
    end
    c_nxt.full = !wr_ready;
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      c_r <= '{instr: IR_RESET, default: '0};
    end else begin
      c_r <= c_nxt;
    end
  end

  // Words pushed while full are dropped; the host sees fifo_full_out only via core
  tap_fifo #(.WIDTH(DR_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_in(core_clk_in),
    .reset_n_in(reset_n_in),
    .wr_data_in(c_r.word),
    .wr_valid_in(c_r.push),
    .wr_ready_out(wr_ready),
    .rd_data_out(rd_data),
    .rd_valid_out(rd_valid),
    .rd_ready_in(pop)
  );

  assign core_data_out = c_r.data;
  assign core_valid_out = c_r.valid;
  assign instr_out = c_r.instr;
  assign fifo_full_out = c_r.full;

  // Link side checks
  chk_tdo_idle_float: assert property (@(negedge test_clk_in) disable iff (!reset_n_in)
    !($past(l_r.st) inside {st_ir_shift, st_dr_shift}) |-> !test_data_oe_out)
    else $error("serial output driven outside shift");
  chk_tdo_shift_drive: assert property (@(negedge test_clk_in) disable iff (!reset_n_in)
    (l_r.st inside {st_ir_shift, st_dr_shift}) |=> test_data_oe_out)
    else $error("serial output not driven in shift");
  chk_tdo_fall_only: assert property (@(negedge test_clk_in) disable iff (!reset_n_in)
    test_data_out == l_r.tdo_rise)
    else $error("serial output moved on rising edge");
  chk_tdo_shift_bit: assert property (@(negedge test_clk_in) disable iff (!reset_n_in)
    (l_r.st == st_dr_shift) |=> (test_data_out == $past(l_r.dr_shift[0])))
    else $error("serial output bit wrong");
  chk_tdi_capture: assert property (@(posedge test_clk_in) disable iff (!reset_n_in)
    (l_r.st == st_dr_shift) |=> (l_r.dr_shift[DR_WIDTH-1] == $past(test_data_in)))
    else $error("input bit not captured");
  chk_five_high_reset: assert property (@(posedge test_clk_in) disable iff (!reset_n_in)
    test_mode_in [*5] |=> (l_r.st == st_reset))
    else $error("five high mode samples did not reset");
  chk_idle_hold: assert property (@(posedge test_clk_in) disable iff (!reset_n_in)
    (l_r.st == st_idle) && !test_mode_in |=> (l_r.st == st_idle))
    else $error("idle left with mode low");
  chk_select_path: assert property (@(posedge test_clk_in) disable iff (!reset_n_in)
    (l_r.st == st_idle) ##0 test_mode_in ##1 test_mode_in ##1 !test_mode_in
    |=> (l_r.st == st_ir_capture))
    else $error("instruction capture path wrong");
  chk_ir_update: assert property (@(posedge test_clk_in) disable iff (!reset_n_in)
    (l_r.st == st_ir_update) |=> (l_r.ir == $past(l_r.ir_shift)))
    else $error("instruction not updated");
  chk_ir_tdi_capture: assert property (@(posedge test_clk_in) disable iff (!reset_n_in)
    (l_r.st == st_ir_shift) |=> (l_r.ir_shift[IR_WIDTH-1] == $past(test_data_in)))
    else $error("instruction bit not captured");
  chk_dr_exit: assert property (@(posedge test_clk_in) disable iff (!reset_n_in)
    (l_r.st == st_dr_shift) && test_mode_in |=> (l_r.st == st_dr_exit1))
    else $error("shift not left with mode high");
  chk_reset_instr: assert property (@(posedge test_clk_in) disable iff (!reset_n_in)
    (l_r.st == st_reset) |-> (l_r.ir == IR_RESET))
    else $error("reset state without reset instruction");
  chk_ir_capture: assert property (@(posedge test_clk_in) disable iff (!reset_n_in)
    (l_r.st == st_ir_capture) |=> (l_r.ir_shift == IR_CAPTURE))
    else $error("instruction capture pattern wrong");
  chk_dr_word_load: assert property (@(posedge test_clk_in) disable iff (!reset_n_in)
    (l_r.st == st_dr_update) && (l_r.ir == IR_USER_DATA) |=> (l_r.dr_word == $past(l_r.dr_shift)))
    else $error("data word not latched");

  // Core side checks
  chk_core_push: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    c_r.push && wr_ready |-> ##1 rd_valid)
    else $error("pushed word not in fifo");
  chk_instr_cross: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    (c_r.ir_sync[2] == c_r.ir_sync[1]) |=> $stable(instr_out))
    else $error("instruction moved without toggle");

endmodule

// >>> pkg/tap_pkg.sv
/*
 Shared types and constants for the serial test access port: tap states,
 instruction and data register widths, capture patterns, FIFO geometry.
 Assumes a single link clock from the host plus a core clock.
*/
package tap_pkg;

  typedef enum logic [3:0] {
    st_reset, st_idle,
    st_dr_select, st_dr_capture, st_dr_shift, st_dr_exit1, st_dr_pause, st_dr_exit2, st_dr_update,
    st_ir_select, st_ir_capture, st_ir_shift, st_ir_exit1, st_ir_pause, st_ir_exit2, st_ir_update
  } tap_state_type;

  localparam int IR_WIDTH = 4;
  localparam int DR_WIDTH = 8;
  localparam logic [IR_WIDTH-1:0] IR_CAPTURE = 4'h1;
  localparam logic [IR_WIDTH-1:0] IR_RESET = 4'hF;
  localparam logic [IR_WIDTH-1:0] IR_USER_DATA = 4'h2;
  localparam int FIFO_DEPTH = 8;

  typedef struct packed {
    logic tms;
    logic tdi;
  } link_in_type;

  typedef struct packed {
    logic tdo;
    logic tdo_oe;
  } link_out_type;

endpackage

// >>> verif/tap_host_model.sv
/*
 Host end of the test link: clock only inside frames, resolved output seen.
 Assumes the bench calls its tasks one at a time.
*/
module tap_host_model (
  // Link toward the device
  output logic tck_out,
  output logic tms_out,
  output logic tdi_out,
  input wire logic tdo_in,
  input wire logic tdo_oe_in
);
  timeunit 1ns;
  timeprecision 1ps;
  wire tdo_line = tdo_oe_in ? tdo_in : 1'bz;
  // Clock parked low, mode and data at their pull-up level
  initial {tck_out, tms_out, tdi_out} = 3'b011;
  task automatic step(input logic tms, input logic tdi, output logic seen);
    tms_out = tms;
    tdi_out = tdi;
    #24 seen = tdo_line;
    tck_out = 1'b1;
    #24 tck_out = 1'b0;
  endtask
  // Idle to shift, n bits, back to idle
  task automatic scan(input logic ir, input logic [7:0] din, input int n,
                      output logic [7:0] dout);
    logic s;
    dout = 8'h00;
    step(1'b1, 1'b1, s);
    if (ir) step(1'b1, 1'b1, s);
    step(1'b0, 1'b1, s);
    step(1'b0, 1'b1, s);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], s);
      dout[i] = s;
    end
    step(1'b1, 1'b1, s);
    step(1'b0, 1'b1, s);
  endtask
endmodule

// >>> verif/tap_port_tb.sv
/*
 Bench: host model on the link, random core back-pressure, expected words
 queued and checked at the core. Assumes the core-side sync latencies.
*/
module tap_port_tb;
  import tap_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic core_ready_in = 1'b0;
  logic stall = 1'b0;
  logic tck, tms, tdi, tdo, tdo_oe, core_valid, fifo_full, s;
  logic [7:0] core_data, d, w, last = 8'h00;
  logic [3:0] instr;
  logic [7:0] exp_q[$];
  int fail_count = 0, samples_checked = 0, cycles = 0, pushed = 0;
  always #2.5 core_clk_in = ~core_clk_in;
  tap_port dut_u (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in), .test_clk_in(tck),
    .test_mode_in(tms), .test_data_in(tdi), .test_data_out(tdo), .test_data_oe_out(tdo_oe),
    .core_data_out(core_data), .core_valid_out(core_valid), .core_ready_in(core_ready_in),
    .instr_out(instr), .fifo_full_out(fifo_full));
  tap_host_model host_u (.tck_out(tck), .tms_out(tms), .tdi_out(tdi), .tdo_in(tdo),
    .tdo_oe_in(tdo_oe));
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      $display("unexpected %s expected %h seen %h", name, exp, seen);
      fail_count++;
    end
  endtask
  task automatic stop_test();
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic drain();
    for (int k = 0; k < 3000 && exp_q.size() > 0; k++) @(posedge core_clk_in);
    check("words_left", 8'(exp_q.size()), 8'h00);
  endtask
  // Noted first: the word may reach the core as the scan returns
  task automatic send(input logic [7:0] v);
    exp_q.push_back(v);
    host_u.scan(1'b0, v, DR_WIDTH, d);
  endtask
  always @(posedge core_clk_in) begin
    core_ready_in <= stall ? 1'b0 : 1'($urandom_range(1, 0));
    if (core_valid === 1'b1 && core_ready_in === 1'b1) begin
      check("core_data", core_data, exp_q.size() ? exp_q.pop_front() : 8'hXX);
    end
    cycles++;
    if (cycles == 30000) begin
      fail_count++;
      stop_test();
    end
  end
  initial begin
    void'($urandom(41));
    host_u.step(1'b1, 1'b1, s);
    repeat (3) @(posedge core_clk_in);
    reset_n_in <= 1'b1;
    repeat (4) @(posedge core_clk_in);
    check("instr_reset", 8'(instr), 8'(IR_RESET));
    check("oe_reset", 8'(tdo_oe), 8'h00);
    host_u.step(1'b0, 1'b1, s);
    check("tdo_idle", 8'(s === 1'bz), 8'h01);
    host_u.scan(1'b1, 8'(IR_USER_DATA), IR_WIDTH, d);
    check("ir_capture", 8'(d[3:0]), 8'(IR_CAPTURE));
    repeat (10) @(posedge core_clk_in);
    check("instr_load", 8'(instr), 8'(IR_USER_DATA));
    check("oe_after", 8'(tdo_oe), 8'h00);
    $display("test ir_load done");
    for (int i = 0; i < 12; i++) begin
      w = 8'($urandom());
      send(w);
      check("dr_out", d, last);
      last = w;
    end
    drain();
    $display("test dr_stream done");
    stall = 1'b1;
    while (fifo_full !== 1'b1 && pushed < 12) begin
      send(8'($urandom()));
      pushed++;
      repeat (10) @(posedge core_clk_in);
    end
    check("fifo_full", 8'(fifo_full), 8'h01);
    check("fill_count", 8'(pushed), 8'(FIFO_DEPTH + 1));
    host_u.scan(1'b0, 8'hA5, DR_WIDTH, d);
    stall = 1'b0;
    drain();
    $display("test fifo_full done");
    for (int i = 0; i < 5; i++) host_u.step(i < 2, i < 3, s);
    check("oe_shift", 8'(tdo_oe), 8'h01);
    repeat (5) host_u.step(1'b1, 1'b1, s);
    repeat (10) @(posedge core_clk_in);
    check("instr_five", 8'(instr), 8'(IR_RESET));
    check("oe_five", 8'(tdo_oe), 8'h00);
    host_u.step(1'b0, 1'b1, s);
    drain();
    $display("test five_high done");
    stop_test();
  end
endmodule
